// *** include/wdt_pkg.sv ***
/*
  Package for the watchdog timer block: APB register map, field positions,
  reset values, timing counts and the packed carrier types.
  Assumes a 20 MHz system clock and a 32-bit APB slave.
*/
package wdt_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_KEY      = 8'h04;
  localparam logic [7:0] ADDR_INTERVAL = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_INT_EN   = 8'h14;

  // ==========================================================
  // Control register fields
  // ==========================================================
  localparam int BIT_RESTART   = 0;
  localparam int BIT_RST_EN    = 1;
  localparam int BIT_RST_CAUSE = 2;
  localparam int BIT_TIMEOUT   = 3;
  localparam int BIT_POWER_UP  = 6;

  // Interval select sits in bits 7:6 of its register
  localparam int BIT_SEL_LOW  = 6;
  localparam int BIT_SEL_HIGH = 7;

  // Interrupt status and mask bits
  localparam int IRQ_TIMEOUT  = 0;
  localparam int IRQ_WDRESET  = 1;
  localparam int IRQ_KEY_FAIL = 2;
  localparam int IRQ_WIDTH    = 3;

  // Interrupt enable register bits
  localparam int BIT_WD_IE     = 0;
  localparam int BIT_GLOBAL_IE = 1;

  // ==========================================================
  // Reset values and keys
  // ==========================================================
  localparam logic [1:0] SEL_RESET   = 2'h0;
  localparam logic [7:0] KEY_FIRST   = 8'hAA;
  localparam logic [7:0] KEY_SECOND  = 8'h55;
  localparam logic [7:0] CONTROL_RST = 8'h00;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int EXP_SEL0 = 17;
  localparam int EXP_SEL1 = 20;
  localparam int EXP_SEL2 = 23;
  localparam int EXP_SEL3 = 26;
  localparam int RESET_DELAY_CLKS = 512;
  localparam int CLK_NS           = 50;
  // Two machine cycles of four clocks each
  localparam int MACHINE_CLKS     = 4;
  localparam int RESET_HOLD_CLKS  = 2 * MACHINE_CLKS;
  localparam int CNT_WIDTH        = 27;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    WDT_IDLE  = 2'b00,
    WDT_COUNT = 2'b01,
    WDT_DELAY = 2'b11,
    WDT_HOLD  = 2'b10
  } wdt_state_type;

  typedef struct packed {
    logic       power_up;
    logic       timeout;
    logic       rst_cause;
    logic       rst_en;
  } wdt_ctrl_type;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } wdt_apb_req_type;

endpackage

// *** hdl/wdt_key.sv ***
/*
  Timed-access key tracker: opens a one-write window after AA then 55.
  Assumes write strobes from the APB slave on the same clock.
*/
`timescale 1ns/100ps
module wdt_key (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic       prot_wr,
  output logic            unlocked,
  output logic            key_fail
);

  logic seen_first_r;
  logic seen_first_nxt;
  logic open_r;
  logic open_nxt;

  // Any key write other than the expected byte drops the sequence
  assign seen_first_nxt = key_wr ? (key_data == wdt_pkg::KEY_FIRST) : seen_first_r;
  assign open_nxt = key_wr ? (seen_first_r && key_data == wdt_pkg::KEY_SECOND)
                  : (prot_wr ? 1'b0 : open_r);
  assign unlocked = open_r;
  assign key_fail = prot_wr && !open_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seen_first_r <= 1'b0;
      open_r       <= 1'b0;
    end else begin
      seen_first_r <= seen_first_nxt;
      open_r       <= open_nxt;
    end
  end

endmodule

// *** hdl/wdt_top.sv ***
/*
  Watchdog timer with APB register access, timed-access protection,
  delayed system reset and a maskable interrupt.
  Assumes RESET_N is synchronous to CLK; POWER_FAIL_N and EXT_RESET_N are
  asynchronous pins and are synchronised here.
*/
`timescale 1ns/100ps
module wdt_top #(
  parameter int DELAY_CLKS = wdt_pkg::RESET_DELAY_CLKS,
  parameter int HOLD_CLKS  = wdt_pkg::RESET_HOLD_CLKS,
  parameter int SHIFT_ADJ  = 0
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        POWER_FAIL_N,
  input  wire logic        EXT_RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             WDT_RESET,
  output logic             WDT_IRQ_REQ,
  output logic             IRQ
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic       pf_meta_r;
  logic       pf_sync_r;
  logic       ext_meta_r;
  logic       ext_sync_r;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pf_meta_r  <= 1'b1;
      pf_sync_r  <= 1'b1;
      ext_meta_r <= 1'b1;
      ext_sync_r <= 1'b1;
    end else begin
      pf_meta_r  <= POWER_FAIL_N;
      pf_sync_r  <= pf_meta_r;
      ext_meta_r <= EXT_RESET_N;
      ext_sync_r <= ext_meta_r;
    end
  end

  wire power_fail = !pf_sync_r;
  wire ext_reset  = !ext_sync_r;

  // ==========================================================
  // APB decode
  // ==========================================================
  wdt_pkg::wdt_apb_req_type req;
  assign req = '{sel: PSEL, wr: PWRITE, addr: PADDR, wdata: PWDATA};

  wire access   = req.sel && PENABLE;
  wire wr_en    = access && req.wr;
  wire hit_ctl  = req.addr == wdt_pkg::ADDR_CONTROL;
  wire hit_key  = req.addr == wdt_pkg::ADDR_KEY;
  wire hit_int  = req.addr == wdt_pkg::ADDR_INTERVAL;
  wire hit_sta  = req.addr == wdt_pkg::ADDR_IRQ_STAT;
  wire hit_msk  = req.addr == wdt_pkg::ADDR_IRQ_MASK;
  wire hit_ien  = req.addr == wdt_pkg::ADDR_INT_EN;
  wire mapped   = hit_ctl | hit_key | hit_int | hit_sta | hit_msk | hit_ien;
  wire wr_ctl   = wr_en && hit_ctl;
  wire wr_key   = wr_en && hit_key;

  assign PREADY  = 1'b1;
  assign PSLVERR = access && !mapped;

  // ==========================================================
  // Timed access
  // ==========================================================
  logic unlocked;
  logic key_fail;

  wdt_key u_key (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .key_wr   (wr_key),
    .key_data (req.wdata[7:0]),
    .prot_wr  (wr_ctl),
    .unlocked (unlocked),
    .key_fail (key_fail)
  );

  wire ctl_wr_ok = wr_ctl && unlocked;

  // ==========================================================
  // Interval select
  // ==========================================================
  function automatic logic [wdt_pkg::CNT_WIDTH-1:0] interval_of(input logic [1:0] sel);
    int e;
    case (sel)
      2'd0:    e = wdt_pkg::EXP_SEL0;
      2'd1:    e = wdt_pkg::EXP_SEL1;
      2'd2:    e = wdt_pkg::EXP_SEL2;
      2'd3:    e = wdt_pkg::EXP_SEL3;
      default: e = wdt_pkg::EXP_SEL0;
    endcase
    e = e - SHIFT_ADJ;
    if (e < 1) e = 1;
    interval_of = wdt_pkg::CNT_WIDTH'(1) << e;
  endfunction

  logic [1:0] sel_r;

  always_ff @(posedge CLK) begin
    if (!RESET_N || power_fail) begin
      sel_r <= wdt_pkg::SEL_RESET;
    end else if (wr_en && hit_int) begin
      sel_r <= req.wdata[wdt_pkg::BIT_SEL_HIGH:wdt_pkg::BIT_SEL_LOW];
    end
  end

  // ==========================================================
  // Counter and state machine
  // ==========================================================
  wdt_pkg::wdt_state_type    state_r;
  wdt_pkg::wdt_state_type    state_nxt;
  logic [wdt_pkg::CNT_WIDTH-1:0] cnt_r;
  logic [wdt_pkg::CNT_WIDTH-1:0] cnt_nxt;
  wdt_pkg::wdt_ctrl_type     ctl_r;
  logic                      enabled_r;

  wire restart   = ctl_wr_ok && req.wdata[wdt_pkg::BIT_RESTART];
  wire [wdt_pkg::CNT_WIDTH-1:0] limit = interval_of(sel_r);
  wire cnt_hit   = cnt_r == limit - wdt_pkg::CNT_WIDTH'(1);
  wire timeout   = state_r == wdt_pkg::WDT_COUNT && cnt_hit;
  wire delay_end = state_r == wdt_pkg::WDT_DELAY
                   && cnt_r == wdt_pkg::CNT_WIDTH'(DELAY_CLKS - 1);
  wire hold_end  = state_r == wdt_pkg::WDT_HOLD
                   && cnt_r == wdt_pkg::CNT_WIDTH'(HOLD_CLKS - 1);
  // External reset restarts the count and enables the watchdog; it never disables it
  wire soft_restart = restart || ext_reset;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + wdt_pkg::CNT_WIDTH'(1);
    case (state_r)
      wdt_pkg::WDT_IDLE: begin
        cnt_nxt = '0;
        if (soft_restart) state_nxt = wdt_pkg::WDT_COUNT;
      end
      wdt_pkg::WDT_COUNT: begin
        if (soft_restart) begin
          cnt_nxt = '0;
        end else if (cnt_hit) begin
          cnt_nxt = '0;
          // Without reset enable the timer keeps dividing freely
          if (ctl_r.rst_en) state_nxt = wdt_pkg::WDT_DELAY;
        end
      end
      wdt_pkg::WDT_DELAY: begin
        if (soft_restart) begin
          cnt_nxt   = '0;
          state_nxt = wdt_pkg::WDT_COUNT;
        end else if (delay_end) begin
          cnt_nxt   = '0;
          state_nxt = wdt_pkg::WDT_HOLD;
        end
      end
      wdt_pkg::WDT_HOLD: begin
        if (hold_end) begin
          cnt_nxt   = '0;
          state_nxt = wdt_pkg::WDT_COUNT;
        end
      end
      default: begin
        cnt_nxt   = '0;
        state_nxt = wdt_pkg::WDT_IDLE;
      end
    endcase
    if (!enabled_r) begin
      state_nxt = soft_restart ? wdt_pkg::WDT_COUNT : wdt_pkg::WDT_IDLE;
      cnt_nxt   = '0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N || power_fail) begin
      state_r   <= wdt_pkg::WDT_IDLE;
      cnt_r     <= '0;
      enabled_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      enabled_r <= enabled_r | soft_restart;
    end
  end

  wire wd_reset_start = delay_end && !soft_restart;

  // ==========================================================
  // Control flags; hardware set wins over software clear
  // ==========================================================
  wdt_pkg::wdt_ctrl_type ctl_nxt;
  logic                  por_done_r;

  always_comb begin
    ctl_nxt = ctl_r;
    if (ctl_wr_ok) begin
      ctl_nxt.power_up  = req.wdata[wdt_pkg::BIT_POWER_UP];
      ctl_nxt.timeout   = req.wdata[wdt_pkg::BIT_TIMEOUT];
      ctl_nxt.rst_en    = req.wdata[wdt_pkg::BIT_RST_EN];
    end
    if (wr_ctl) begin
      ctl_nxt.rst_cause = req.wdata[wdt_pkg::BIT_RST_CAUSE];
    end
    if (timeout) ctl_nxt.timeout = 1'b1;
    if (wd_reset_start && ctl_r.rst_en) ctl_nxt.rst_cause = 1'b1;
    if (!por_done_r) ctl_nxt.power_up = 1'b1;
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ctl_r      <= '0;
      por_done_r <= 1'b0;
    end else if (power_fail) begin
      ctl_r      <= '0;
      por_done_r <= 1'b0;
    end else begin
      ctl_r      <= ctl_nxt;
      por_done_r <= 1'b1;
    end
  end

  // ==========================================================
  // Interrupt enables and status
  // ==========================================================
  logic [1:0]                  ien_r;
  logic [wdt_pkg::IRQ_WIDTH-1:0] stat_r;
  logic [wdt_pkg::IRQ_WIDTH-1:0] mask_r;
  logic [wdt_pkg::IRQ_WIDTH-1:0] evt;

  assign evt = {key_fail, wd_reset_start, timeout};
  wire [wdt_pkg::IRQ_WIDTH-1:0] w1c = (wr_en && hit_sta)
                                      ? req.wdata[wdt_pkg::IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ien_r  <= '0;
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      stat_r <= (stat_r & ~w1c) | evt;
      if (wr_en && hit_msk) mask_r <= req.wdata[wdt_pkg::IRQ_WIDTH-1:0];
      if (wr_en && hit_ien) ien_r <= req.wdata[1:0];
    end
  end

  assign IRQ         = |(stat_r & mask_r);
  assign WDT_RESET   = state_r == wdt_pkg::WDT_HOLD;
  assign WDT_IRQ_REQ = ctl_r.timeout && ien_r[wdt_pkg::BIT_WD_IE]
                       && ien_r[wdt_pkg::BIT_GLOBAL_IE];

  // ==========================================================
  // Read data
  // ==========================================================
  logic [7:0]  ctl_view;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;

  always_comb begin
    ctl_view = wdt_pkg::CONTROL_RST;
    ctl_view[wdt_pkg::BIT_POWER_UP]  = ctl_r.power_up;
    ctl_view[wdt_pkg::BIT_TIMEOUT]   = ctl_r.timeout;
    ctl_view[wdt_pkg::BIT_RST_CAUSE] = ctl_r.rst_cause;
    ctl_view[wdt_pkg::BIT_RST_EN]    = ctl_r.rst_en;
  end

  always_comb begin
    rdata_nxt = '0;
    if (hit_ctl) rdata_nxt[7:0] = ctl_view;
    if (hit_int) rdata_nxt[wdt_pkg::BIT_SEL_HIGH:wdt_pkg::BIT_SEL_LOW] = sel_r;
    if (hit_sta) rdata_nxt[wdt_pkg::IRQ_WIDTH-1:0] = stat_r;
    if (hit_msk) rdata_nxt[wdt_pkg::IRQ_WIDTH-1:0] = mask_r;
    if (hit_ien) rdata_nxt[1:0] = ien_r;
  end

  // Read data registered in setup so it is stable in the access phase
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rdata_r <= '0;
    end else if (req.sel && !PENABLE && !req.wr) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign PRDATA = rdata_r;

endmodule

// *** test/wdt_monitor.sv ***
/*
  Port-level checker for the watchdog block: APB answers, read-back layout,
  reset pulse length and interrupt gating.
  Assumes it is bound to wdt_top and sees only that module's ports.
*/
`timescale 1ns/100ps
module wdt_monitor #(
  parameter int DELAY_CLKS = 512,
  parameter int HOLD_CLKS  = 8,
  parameter int SHIFT_ADJ  = 0
) (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        POWER_FAIL_N,
  input wire logic        EXT_RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        WDT_RESET,
  input wire logic        WDT_IRQ_REQ,
  input wire logic        IRQ
);
  // ==========================================================
  // Shadow of the enable and mask registers
  // ==========================================================
  logic       wr_acc;
  logic       rd_acc;
  logic       mapped;
  logic       ctrl_rd;
  logic [1:0] ie_r;
  logic [2:0] mask_r;
  logic [7:0] run_r;

  assign wr_acc  = PSEL && PENABLE && PWRITE;
  assign rd_acc  = PSEL && PENABLE && !PWRITE;
  assign mapped  = (PADDR[1:0] == 2'h0) && (PADDR <= wdt_pkg::ADDR_INT_EN);
  assign ctrl_rd = rd_acc && (PADDR == wdt_pkg::ADDR_CONTROL);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ie_r   <= 2'h0;
      mask_r <= 3'h0;
    end else if (wr_acc && PADDR == wdt_pkg::ADDR_INT_EN) begin
      ie_r   <= PWDATA[1:0];
    end else if (wr_acc && PADDR == wdt_pkg::ADDR_IRQ_MASK) begin
      mask_r <= PWDATA[2:0];
    end
  end

  // Length of the current reset pulse, zero while it is low
  always_ff @(posedge CLK) begin
    run_r <= (!RESET_N || !WDT_RESET) ? 8'h00 : run_r + 8'h01;
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  chk_ready_high: assert property (PREADY)
    else $error("pready low");
  chk_slverr_map: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
    else $error("pslverr does not match address map");
  chk_unmapped_zero: assert property (rd_acc && !mapped |-> PRDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_read_upper: assert property (rd_acc |-> PRDATA[31:8] == 24'h00_0000)
    else $error("read data above byte not zero");
  chk_ctrl_reserved: assert property (ctrl_rd |-> !PRDATA[7] && PRDATA[5:4] == 2'h0)
    else $error("reserved control bits not zero");
  chk_restart_clear: assert property (ctrl_rd |-> !PRDATA[0])
    else $error("restart bit reads back set");
  chk_hold_run: assert property ($rose(WDT_RESET) |=> WDT_RESET [*7])
    else $error("reset pulse ended early");
  chk_hold_len: assert property ($fell(WDT_RESET) |-> run_r == HOLD_CLKS)
    else $error("reset pulse length wrong");
  chk_irq_enables: assert property (WDT_IRQ_REQ |-> ie_r == 2'h3)
    else $error("interrupt request without both enables");
  chk_irq_mask: assert property (IRQ |-> mask_r != 3'h0)
    else $error("irq with all sources masked");
  chk_reset_quiet: assert property ($rose(RESET_N) |-> !WDT_RESET && !IRQ && !WDT_IRQ_REQ)
    else $error("outputs active right after reset");
endmodule

// *** test/wdt_top_tb_top.sv ***
/*
  Self-checking bench for the watchdog block: locked and unlocked control
  writes, every interval code, timed reset, external and power-fail reset.
  Assumes the design package is compiled first and SHIFT_ADJ shortens the interval counts.
*/
`timescale 1ns/100ps
module wdt_top_tb_top;
  localparam int SHIFT = 12;
  logic        clk = 1'b0;
  logic        reset_n, power_fail_n, ext_reset_n;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rdata, prdata;
  logic        pready, pslverr, wdt_reset, wdt_irq_req, irq;
  int          fails = 0;
  int          cmp_count = 0;
  int          seed = 32'hfe1a_2695;
  int          n, p;
  logic [31:0] rnd;

  always #25 clk = ~clk;

  wdt_top #(.SHIFT_ADJ(SHIFT)) dut (
    .CLK(clk), .RESET_N(reset_n), .POWER_FAIL_N(power_fail_n), .EXT_RESET_N(ext_reset_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .WDT_RESET(wdt_reset),
    .WDT_IRQ_REQ(wdt_irq_req), .IRQ(irq));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic complete_run;
    $display("fails %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // A slave that never answers counts against the run
    if (pready !== 1'b1) fails++;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic key_ctrl(input logic [7:0] v);
    apb(1'b1, wdt_pkg::ADDR_KEY, {24'h00_0000, wdt_pkg::KEY_FIRST});
    apb(1'b1, wdt_pkg::ADDR_KEY, {24'h00_0000, wdt_pkg::KEY_SECOND});
    apb(1'b1, wdt_pkg::ADDR_CONTROL, {24'h00_0000, v});
  endtask

  // Edges until irq (0), reset high (1) or reset low (2), capped at l
  function automatic logic seen_evt(input int w);
    return (w == 0) ? irq === 1'b1 : (w == 1) ? wdt_reset === 1'b1 : wdt_reset === 1'b0;
  endfunction

  task automatic wait_on(input int w, input int l);
    n = 0;
    #1;
    while (n < l && !seen_evt(w)) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  function automatic int period(input int sel);
    return 1 << (wdt_pkg::EXP_SEL0 + 3 * sel - SHIFT);
  endfunction

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    reset_n = 1'b0;
    power_fail_n = 1'b1;
    ext_reset_n = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, wdt_pkg::ADDR_CONTROL, 32'h0); check("ctrl_reset", rdata, 32'h0000_0040);
    apb(1'b0, wdt_pkg::ADDR_INTERVAL, 32'h0); check("sel_reset", rdata, 32'h0);
    apb(1'b1, wdt_pkg::ADDR_CONTROL, 32'h0000_004B);
    apb(1'b0, wdt_pkg::ADDR_CONTROL, 32'h0); check("ctrl_locked", rdata, 32'h0000_0040);
    apb(1'b1, wdt_pkg::ADDR_IRQ_MASK, 32'h4); wait_on(0, 2); check("irq_key_fail", irq, 1);
    apb(1'b1, wdt_pkg::ADDR_IRQ_MASK, 32'h0); #1 check("irq_masked", irq, 0);
    apb(1'b1, wdt_pkg::ADDR_IRQ_MASK, 32'h4);
    apb(1'b1, wdt_pkg::ADDR_IRQ_STAT, 32'h4); #1 check("irq_cleared", irq, 0);
    apb(1'b1, 8'h18, 32'hffff_ffff);
    apb(1'b0, 8'h18, 32'h0); check("unmapped_read", rdata, 32'h0);
    rnd = $random(seed);
    apb(1'b1, wdt_pkg::ADDR_IRQ_MASK, rnd);
    apb(1'b0, wdt_pkg::ADDR_IRQ_MASK, 32'h0); check("mask_readback", rdata, rnd & 32'h0000_0007);
    apb(1'b1, wdt_pkg::ADDR_IRQ_MASK, 32'h1);
    key_ctrl(8'h00);
    apb(1'b0, wdt_pkg::ADDR_CONTROL, 32'h0); check("power_up_clear", rdata, 32'h0);
    for (int sel = 0; sel < 4; sel++) begin
      p = period(sel);
      apb(1'b1, wdt_pkg::ADDR_INTERVAL, 32'(sel << 6));
      apb(1'b1, wdt_pkg::ADDR_INT_EN, (sel % 2) ? 32'h3 : 32'h1);
      key_ctrl(8'h01);
      // Random kick point: restart must discard the partial count
      repeat ($unsigned($random(seed)) % 16) @(posedge clk);
      apb(1'b1, wdt_pkg::ADDR_IRQ_STAT, 32'h1);
      key_ctrl(8'h01);
      wait_on(0, 2 * p); check("timeout_time", n >= p - 1 && n <= p + 3, 1);
      check("irq_request", wdt_irq_req, sel % 2);
      apb(1'b0, wdt_pkg::ADDR_CONTROL, 32'h0); check("ctrl_timeout", rdata, 32'h8);
      key_ctrl(8'h00);
      apb(1'b1, wdt_pkg::ADDR_IRQ_STAT, 32'h1);
    end
    apb(1'b1, wdt_pkg::ADDR_INTERVAL, 32'h0);
    @(posedge clk) ext_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    ext_reset_n <= 1'b1;
    apb(1'b1, wdt_pkg::ADDR_IRQ_STAT, 32'h1);
    // Restart lands on the last edge of the synchronised pulse
    wait_on(0, 200); check("ext_restart", n >= period(0) - 4 && n <= period(0), 1);
    key_ctrl(8'h03);
    apb(1'b1, wdt_pkg::ADDR_IRQ_STAT, 32'h1);
    wait_on(0, 100);
    wait_on(1, 700); p = wdt_pkg::RESET_DELAY_CLKS;
    check("reset_delay", n >= p - 1 && n <= p + 1, 1);
    wait_on(2, 20); check("reset_hold", n, wdt_pkg::RESET_HOLD_CLKS);
    apb(1'b0, wdt_pkg::ADDR_CONTROL, 32'h0); check("ctrl_wd_reset", rdata & 32'h6, 32'h6);
    @(posedge clk) power_fail_n <= 1'b0;
    repeat (4) @(posedge clk);
    power_fail_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, wdt_pkg::ADDR_CONTROL, 32'h0); check("ctrl_power_fail", rdata & 32'h6, 32'h0);
    apb(1'b1, wdt_pkg::ADDR_IRQ_STAT, 32'h7);
    wait_on(0, 100); check("disabled_no_timeout", n, 100);
    wait_on(1, 700); check("disabled_no_reset", n, 700);
    complete_run;
  end

  // Longest path is the interval loop, roughly 19k clocks
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    complete_run;
  end
endmodule

bind wdt_top wdt_monitor #(.DELAY_CLKS(DELAY_CLKS), .HOLD_CLKS(HOLD_CLKS), .SHIFT_ADJ(SHIFT_ADJ))
  u_mon (.CLK(CLK), .RESET_N(RESET_N), .POWER_FAIL_N(POWER_FAIL_N), .EXT_RESET_N(EXT_RESET_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .WDT_RESET(WDT_RESET),
  .WDT_IRQ_REQ(WDT_IRQ_REQ), .IRQ(IRQ));
